/* File: common/tocp_params.svh */
// Register offsets, field positions, reset values and widths of the output compare block.
`ifndef TOCP_PARAMS_SVH
`define TOCP_PARAMS_SVH
`define TOCP_ADDR_W        4
`define TOCP_DATA_W        16
`define TOCP_NUM_CHAN      6
`define TOCP_NUM_PAIR      3
`define TOCP_ADDR_CTRL0    4'h0
`define TOCP_ADDR_MOD      4'hC
`define TOCP_ADDR_OVF      4'hD
`define TOCP_CTRL_FLAG_BIT 7
`define TOCP_OVF_FLAG_BIT  1
`define TOCP_OVF_IE_BIT    0
`define TOCP_CTRL_RESET    8'h00
`define TOCP_VALUE_RESET   16'h0000
`define TOCP_MOD_RESET     16'hFFFF
`define TOCP_DATA_ZERO     16'h0000
`endif

/* File: common/tocp_pkg.sv */
// Types shared by the output compare block and its bench.
package tocp_pkg;
    // Channel mode codes; any code with the upper bit set in an even channel links its pair.
    typedef enum logic [1:0] {
        TOCP_MODE_CAPTURE  = 2'b00,
        TOCP_MODE_UNBUF    = 2'b01,
        TOCP_MODE_BUF      = 2'b10,
        TOCP_MODE_BUF_ALT  = 2'b11
    } tocp_mode_t;
    // Compare action codes.
    typedef enum logic [1:0] {
        TOCP_ACT_NONE   = 2'b00,
        TOCP_ACT_TOGGLE = 2'b01,
        TOCP_ACT_CLEAR  = 2'b10,
        TOCP_ACT_SET    = 2'b11
    } tocp_action_t;
    // Channel control and status byte.
    typedef struct packed {
        logic         flag;
        logic         irq_enable;
        tocp_mode_t   chan_mode_field;
        tocp_action_t compare_action_field;
        logic         toggle_on_overflow_bit;
        logic         max_duty_bit;
    } tocp_ctrl_t;
    // Register port request from software.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } tocp_bus_req_t;
    // Shared timer counter as seen by this block.
    typedef struct packed {
        logic        tick;
        logic [15:0] count;
    } tocp_counter_t;
endpackage : tocp_pkg

/* File: verilog/tocp_top.sv */
// Output compare and PWM stage of a six-channel 16-bit timer.
// Function
// - Unbuffered write replaces compare value immediately.
// - Match only when counter equals stored value.
// - Compare match sets channel flag, requests interrupt; a match on the overflow tick with toggle on overflow set does neither.
// - Overflow sets overflow flag, requests interrupt.
// - Link bit pairs channels 0/1, even first.
// - Channels 2/3 and 4/5 pair likewise.
// - Last written set takes control at overflow.
// - Even control register governs linked pair.
// - Odd pin released while pair linked.
// - Toggle on overflow makes period.
// - Period is modulo value plus one.
// - Compare value sets the pulse width.
// - Buffered change starts at next period.
// - Mode code 0:1 unbuffered, 1:0 buffered.
// - Action 1:0 clears, 1:1 sets output.
// - No overflow toggle, clear action and no max duty give zero duty.
// - Max duty without toggle holds output high.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "tocp_params.svh"

module tocp_top
    import tocp_pkg::*;
(
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire tocp_bus_req_t               bus_req,
    output logic [`TOCP_DATA_W-1:0]          rdata,
    input  wire tocp_counter_t               counter,
    output logic [`TOCP_NUM_CHAN-1:0]        chan_pin_out,
    output logic [`TOCP_NUM_CHAN-1:0]        chan_pin_oe,
    output logic [`TOCP_NUM_CHAN-1:0]        chan_irq,
    output logic                             ovf_irq
);

    // Control bytes of the six channels.
    tocp_ctrl_t                      ctrl [`TOCP_NUM_CHAN];
    // Compare values of the six channels.
    logic [`TOCP_DATA_W-1:0]         value [`TOCP_NUM_CHAN];
    // Modulo value of the shared counter.
    logic [`TOCP_DATA_W-1:0]         modulo;
    // Sticky overflow flag and its interrupt enable.
    logic                            ovf_flag;
    logic                            ovf_ie;
    // Which half of each pair currently drives the compare.
    logic                            pair_sel [`TOCP_NUM_PAIR];
    // Which half of each pair was written last.
    logic                            pair_last [`TOCP_NUM_PAIR];
    // Per-channel match pulse, used to set the flag.
    logic                            match_hit [`TOCP_NUM_CHAN];
    // Overflow event: the counter rolls from the modulo value to zero.
    logic                            overflow;
    // Write decode for the overflow register.
    logic                            wr_ovf;

    // A timer clock edge with the counter sitting on the modulo value is the
    // rollover cycle, so the pin toggle and the pair swap share this pulse.
    assign overflow = counter.tick && (counter.count == modulo);
    assign wr_ovf   = bus_req.wr && (bus_req.addr == `TOCP_ADDR_OVF);

    // Modulo register; software sets the PWM period with it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            modulo <= `TOCP_MOD_RESET;
        end else if (bus_req.wr && (bus_req.addr == `TOCP_ADDR_MOD)) begin
            modulo <= bus_req.wdata;
        end
    end

    // Overflow flag: writing one clears it, but a fresh overflow in the
    // same cycle wins so that no period goes unreported.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ovf_flag <= 1'b0;
            ovf_ie   <= 1'b0;
        end else begin
            if (overflow) begin
                ovf_flag <= 1'b1;
            end else if (wr_ovf && bus_req.wdata[`TOCP_OVF_FLAG_BIT]) begin
                ovf_flag <= 1'b0;
            end
            if (wr_ovf) begin
                ovf_ie <= bus_req.wdata[`TOCP_OVF_IE_BIT];
            end
        end
    end

    // Overflow interrupt request, registered so it is glitch free.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ovf_irq <= 1'b0;
        end else begin
            ovf_irq <= ovf_flag && ovf_ie;
        end
    end

    // Pair bookkeeping: remember the last written half and swap on overflow.
    for (genvar p = 0; p < `TOCP_NUM_PAIR; p++) begin : g_pair
        // The even channel's mode field alone decides whether the pair is linked.
        logic linked;
        logic wr_even;
        logic wr_odd;
        assign linked  = ctrl[2*p].chan_mode_field[1];
        assign wr_even = bus_req.wr && (bus_req.addr == 4'((4*p)+1));
        assign wr_odd  = bus_req.wr && (bus_req.addr == 4'((4*p)+3));

        // Last written half; a write to the active half simply updates it.
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                pair_last[p] <= 1'b0;
            end else if (!linked) begin
                pair_last[p] <= 1'b0;
            end else if (wr_odd) begin
                pair_last[p] <= 1'b1;
            end else if (wr_even) begin
                pair_last[p] <= 1'b0;
            end
        end

        // Active half; while linked it only changes at the rollover so a period is never
        // cut short by a buffered update.
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                pair_sel[p] <= 1'b0;
            end else if (!linked) begin
                pair_sel[p] <= 1'b0;
            end else if (overflow) begin
                pair_sel[p] <= pair_last[p];
            end
        end
    end

    // Per-channel registers and pin logic.
    for (genvar i = 0; i < `TOCP_NUM_CHAN; i++) begin : g_chan
        localparam int EVEN = i - (i % 2);
        localparam int ODD  = EVEN + 1;
        localparam logic [3:0] CTRL_ADDR = 4'(2*i);
        localparam logic [3:0] VAL_ADDR  = 4'((2*i)+1);

        // Whether this channel's pair is linked.
        logic        linked;
        // Whether this channel runs its own compare logic.
        logic        active;
        // Compare value in force for this channel.
        logic [15:0] cmp_value;
        // Write decodes.
        logic        wr_ctrl;
        logic        wr_val;
        // Compare equality for this timer clock.
        logic        cmp_equal;
        // Decoded control fields.
        tocp_ctrl_t  c;

        assign c       = ctrl[i];
        assign linked  = ctrl[EVEN].chan_mode_field[1];
        // A linked odd channel goes quiet; its control byte has no effect.
        assign active  = ((i % 2) == 0) || !linked;
        assign wr_ctrl = bus_req.wr && (bus_req.addr == CTRL_ADDR);
        assign wr_val  = bus_req.wr && (bus_req.addr == VAL_ADDR);
        // The even channel of a linked pair compares against the active half.
        assign cmp_value = (((i % 2) == 0) && linked && pair_sel[i/2]) ?
                           value[ODD] : value[i];
        // Only exact equality matches, so a value lowered below the count
        // waits a whole period.
        assign cmp_equal = counter.tick && (counter.count == cmp_value);
        assign match_hit[i] = active && cmp_equal && !(overflow && c.toggle_on_overflow_bit)
                              && (c.chan_mode_field != TOCP_MODE_CAPTURE);

        // Compare value: a write lands directly and is used at the next
        // comparison; buffering only comes from the pair selection.
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                value[i] <= `TOCP_VALUE_RESET;
            end else if (wr_val) begin
                value[i] <= bus_req.wdata;
            end
        end

        // Control byte; the flag is cleared by writing one, and a match in
        // the same cycle keeps it set.
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                ctrl[i] <= tocp_ctrl_t'(`TOCP_CTRL_RESET);
            end else begin
                if (wr_ctrl) begin
                    ctrl[i].irq_enable             <= bus_req.wdata[6];
                    ctrl[i].chan_mode_field        <= tocp_mode_t'(bus_req.wdata[5:4]);
                    ctrl[i].compare_action_field   <= tocp_action_t'(bus_req.wdata[3:2]);
                    ctrl[i].toggle_on_overflow_bit <= bus_req.wdata[1];
                    ctrl[i].max_duty_bit           <= bus_req.wdata[0];
                end
                if (match_hit[i]) begin
                    ctrl[i].flag <= 1'b1;
                end else if (wr_ctrl && bus_req.wdata[`TOCP_CTRL_FLAG_BIT]) begin
                    ctrl[i].flag <= 1'b0;
                end
            end
        end

        // Channel interrupt request; a linked odd channel never asks.
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                chan_irq[i] <= 1'b0;
            end else begin
                chan_irq[i] <= active && c.flag && c.irq_enable;
            end
        end

        // Pin enable: driven only in a compare mode with an action chosen,
        // and released altogether when the odd half of a linked pair.
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                chan_pin_oe[i] <= 1'b0;
            end else begin
                chan_pin_oe[i] <= active &&
                                  (c.chan_mode_field != TOCP_MODE_CAPTURE) &&
                                  (c.compare_action_field != TOCP_ACT_NONE);
            end
        end

        // Pin level. The overflow toggle takes priority over a match on the
        // same timer clock. Toggle-on-compare is honoured but is a poor PWM
        // choice since it never self corrects after a missed compare.
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                chan_pin_out[i] <= 1'b0;
            end else if (!active || (c.chan_mode_field == TOCP_MODE_CAPTURE)) begin
                chan_pin_out[i] <= 1'b0;
            end else if (c.max_duty_bit && !c.toggle_on_overflow_bit) begin
                chan_pin_out[i] <= 1'b1;
            end else if (overflow && c.toggle_on_overflow_bit) begin
                chan_pin_out[i] <= !chan_pin_out[i];
            end else if (match_hit[i]) begin
                unique case (c.compare_action_field)
                    TOCP_ACT_TOGGLE: begin
                        chan_pin_out[i] <= !chan_pin_out[i];
                    end
                    TOCP_ACT_CLEAR: begin
                        chan_pin_out[i] <= 1'b0;
                    end
                    TOCP_ACT_SET: begin
                        chan_pin_out[i] <= 1'b1;
                    end
                    TOCP_ACT_NONE: begin
                        chan_pin_out[i] <= chan_pin_out[i];
                    end
                endcase
            end
        end
    end

    // Read data, valid only in the cycle after the read strobe; unmapped
    // addresses and idle cycles read as zero.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata <= `TOCP_DATA_ZERO;
        end else if (bus_req.rd) begin
            if (bus_req.addr < `TOCP_ADDR_MOD) begin
                if (bus_req.addr[0]) begin
                    rdata <= value[bus_req.addr[3:1]];
                end else begin
                    rdata <= {8'h00, ctrl[bus_req.addr[3:1]]};
                end
            end else if (bus_req.addr == `TOCP_ADDR_MOD) begin
                rdata <= modulo;
            end else if (bus_req.addr == `TOCP_ADDR_OVF) begin
                rdata <= {14'h0000, ovf_flag, ovf_ie};
            end else begin
                rdata <= `TOCP_DATA_ZERO;
            end
        end else begin
            rdata <= `TOCP_DATA_ZERO;
        end
    end

endmodule : tocp_top

/* File: tb/tocp_props.sv */
// Checker on the ports of the output compare block.
`timescale 1ns/1ps
`include "tocp_params.svh"
module tocp_props
    import tocp_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire tocp_bus_req_t        bus_req,
    input wire logic [15:0]          rdata,
    input wire tocp_counter_t        counter,
    input wire logic [5:0]           chan_pin_out,
    input wire logic [5:0]           chan_pin_oe,
    input wire logic [5:0]           chan_irq,
    input wire logic                 ovf_irq
);
    logic [15:0] mod_sh;     // Modulo value as last written.
    logic        ovf_ie_sh;  // Overflow interrupt enable as last written.
    // Shadows follow the write strobe so overflow can be judged from the ports alone.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mod_sh    <= `TOCP_MOD_RESET;
            ovf_ie_sh <= 1'h0;
        end else if (bus_req.wr && bus_req.addr == `TOCP_ADDR_MOD) begin
            mod_sh <= bus_req.wdata;
        end else if (bus_req.wr && bus_req.addr == `TOCP_ADDR_OVF) begin
            ovf_ie_sh <= bus_req.wdata[`TOCP_OVF_IE_BIT];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_mod_readback;
        bus_req.wr && bus_req.addr == `TOCP_ADDR_MOD ##2 bus_req.rd && bus_req.addr == 4'hC
            |=> rdata == $past(bus_req.wdata, 3);
    endproperty
    a_mod_readback: assert property (p_mod_readback) else $error("modulo readback");
    property p_rdata_idle;
        !bus_req.rd |=> rdata == `TOCP_DATA_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_ovf_irq;
        counter.tick && counter.count == mod_sh && ovf_ie_sh |-> ##2 ovf_irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");
    property p_ovf_cause;
        $rose(ovf_irq) |-> $past(counter.tick, 2) || $past(bus_req.wr, 2);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("overflow request uncaused");
    property p_chan_cause;
        $rose(chan_irq[0]) |-> $past(counter.tick, 2) || $past(bus_req.wr, 2);
    endproperty
    a_chan_cause: assert property (p_chan_cause) else $error("channel request uncaused");
    property p_irq_fall;
        $fell(ovf_irq) || $fell(chan_irq[0]) |-> $past(bus_req.wr) || $past(bus_req.wr, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
    property p_pin_on_tick;
        !counter.tick && !bus_req.wr && !$past(bus_req.wr) |=> $stable(chan_pin_out);
    endproperty
    a_pin_on_tick: assert property (p_pin_on_tick) else $error("pin moved idle");
    property p_oe_on_write;
        !bus_req.wr && !$past(bus_req.wr) |=> $stable(chan_pin_oe);
    endproperty
    a_oe_on_write: assert property (p_oe_on_write) else $error("enable moved idle");
endmodule : tocp_props
bind tocp_top tocp_props u_props (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .counter(counter), .chan_pin_out(chan_pin_out),
    .chan_pin_oe(chan_pin_oe), .chan_irq(chan_irq), .ovf_irq(ovf_irq));

/* File: tb/tocp_pin_load.sv */
// Model of the circuitry on the channel pins.
`timescale 1ns/1ps
module tocp_pin_load
    import tocp_pkg::*;
(
    input  wire logic [5:0] chan_pin_out,
    input  wire logic [5:0] chan_pin_oe,
    output logic      [5:0] pin_level
);
    // A weak pull-down takes any released pin low, so a stale level can never pass.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_level[i] = chan_pin_oe[i] ? chan_pin_out[i] : 1'h0;
        end
    end
endmodule : tocp_pin_load

/* File: tb/tocp_top_tb.sv */
// Self-checking bench for the output compare and PWM block.
`timescale 1ns/1ps
`include "tocp_params.svh"
module tocp_top_tb
    import tocp_pkg::*;
;
    logic          core_clk = 1'h0;
    logic          rst      = 1'h1;
    tocp_bus_req_t bus_req  = '0;
    tocp_counter_t counter  = '0;
    logic          tick_en  = 1'h0;      // Lets the counter model run.
    logic          rd_d     = 1'h0;      // A read was sampled at the last edge.
    logic [15:0]   mod_val  = 16'h0007;  // Wrap value of the counter model.
    logic [15:0]   rdata;
    logic [5:0]    pin_out, pin_oe, chan_irq, pin_level;
    logic          ovf_irq;
    logic [15:0]   exp_q[$];             // Expected read data, oldest first.
    int            failures = 0, check_count = 0, cycles = 0, seed = 32'h7e1a1ec5;
    int            v, h1, h2, h3, per;
    always #20 core_clk = ~core_clk;
    tocp_top dut (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .counter(counter), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe),
        .chan_irq(chan_irq), .ovf_irq(ovf_irq));
    tocp_pin_load load (.chan_pin_out(pin_out), .chan_pin_oe(pin_oe), .pin_level(pin_level));
    // Shared counter: random ticks, so pulse widths are counted in ticks, not cycles.
    always @(posedge core_clk) begin
        if (counter.tick) begin
            counter.count <= (counter.count == mod_val) ? 16'h0000 : counter.count + 16'h0001;
        end
        counter.tick <= tick_en & 1'($random(seed));
    end
    // Read data is compared with the oldest note; a hung run is cut short.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        rd_d   <= bus_req.rd;
        if (rd_d) begin
            check(rdata, exp_q.pop_front(), "rdata");
        end
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One access, then an idle cycle so strobes never collide.
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
                       input logic [15:0] e);
        @(posedge core_clk);
        bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        if (!w) begin
            exp_q.push_back(e);
        end
        @(posedge core_clk);
        bus_req <= '0;
    endtask : bus
    function automatic logic [15:0] cw(input tocp_mode_t m, input tocp_action_t a,
                                       input logic t, input logic x, input logic ie);
        return {8'h00, 1'h0, ie, m, a, t, x};
    endfunction : cw
    // Counts ticks and high ticks of channel 0 until its next rising edge.
    task automatic measure(output int hi, output int p);
        logic low;
        hi  = 0;
        p   = 0;
        low = 1'h0;
        for (int g = 0; g < 999 && !(low && pin_level[0] === 1'h1); g++) begin
            if (counter.tick) begin
                p++;
                hi += pin_level[0];
            end
            low |= (pin_level[0] === 1'h0);
            @(negedge core_clk);
        end
    endtask : measure
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        // Reset values everywhere; the two top indexes are unmapped.
        for (int a = 0; a < 16; a++) begin
            bus(1'h0, 4'(a), 16'h0000, (a == 12) ? `TOCP_MOD_RESET : 16'h0000);
        end
        bus(1'h1, `TOCP_ADDR_MOD, mod_val, 16'h0000);
        bus(1'h0, `TOCP_ADDR_MOD, 16'h0000, mod_val);
        bus(1'h1, `TOCP_ADDR_OVF, 16'h0001, 16'h0000);
        v = 1 + ($random(seed) & 3);
        bus(1'h1, 4'h1, 16'(v), 16'h0000);
        bus(1'h1, 4'h0, cw(TOCP_MODE_UNBUF, TOCP_ACT_CLEAR, 1'h1, 1'h0, 1'h1), 16'h0000);
        tick_en <= 1'h1;
        measure(h1, per);
        measure(h1, per);
        check(16'(per), mod_val + 16'h0001, "period");
        bus(1'h1, 4'h1, 16'(v + 2), 16'h0000);
        measure(h2, per);
        measure(h2, per);
        check(16'(h2 - h1), 16'h0002, "width step");
        // Lowering only after this period's compare has passed keeps every period whole.
        wait (pin_level[0] === 1'h0);
        bus(1'h1, 4'h1, 16'(v), 16'h0000);
        measure(h3, per);
        measure(h3, per);
        check(16'(h3 - h1), 16'h0000, "width back");
        check(16'({chan_irq[0], ovf_irq}), 16'h0003, "irq");
        tick_en <= 1'h0;
        bus(1'h0, 4'h0, 16'h0000, 16'h00DA);
        bus(1'h1, 4'h0, 16'h00DA, 16'h0000);
        repeat (3) @(posedge core_clk);
        check(16'(chan_irq[0]), 16'h0000, "irq clear");
        tick_en <= 1'h1;
        // Without overflow toggles the level is fixed by action and full-duty bit.
        for (int k = 0; k < 3; k++) begin
            bus(1'h1, 4'h0, cw(TOCP_MODE_UNBUF, (k == 2) ? TOCP_ACT_SET : TOCP_ACT_CLEAR,
                1'h0, k == 0, 1'h0), 16'h0000);
            repeat (60) @(posedge core_clk);
            check(16'(pin_level[0]), 16'(k != 1), "fixed level");
        end
        // Link all pairs; the odd control register must stay without effect.
        bus(1'h1, 4'h1, 16'h0002, 16'h0000);
        for (int p = 0; p < 3; p++) begin
            bus(1'h1, 4'(4 * p), cw(TOCP_MODE_BUF, TOCP_ACT_CLEAR, 1'h1, 1'h0, 1'h0), 16'h0000);
        end
        bus(1'h1, 4'h2, cw(TOCP_MODE_UNBUF, TOCP_ACT_SET, 1'h1, 1'h1, 1'h1), 16'h0000);
        repeat (2) @(posedge core_clk);
        check(16'({pin_oe, pin_level[1]}), 16'h002A, "linked pins");
        measure(h1, per);
        measure(h1, per);
        fork
            measure(h2, per);
            bus(1'h1, 4'h3, 16'h0006, 16'h0000);
        join
        measure(h3, per);
        check(16'(h2 - h1), 16'h0000, "mid period");
        check(16'(h3 - h1), 16'h0004, "swap");
        bus(1'h1, 4'h1, 16'h0003, 16'h0000);
        measure(h2, per);
        measure(h3, per);
        check(16'(h3 - h1), 16'h0001, "swap back");
        tally_and_finish();
    end
    task automatic tally_and_finish();
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
endmodule : tocp_top_tb
